// ### logic/etec_top.sv
// Trigger, exposure timing, sync outputs and indicator lamps
// --------------------------------------------------------------
// --------------------------------------------------------------
`include "etec_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module etec_top
   import etec_pkg::*;
#(
   parameter int W = `ETEC_EXP_W
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          reset,
   // Trigger pin, active low
   input  wire logic          trig_n,
   // Configuration
   input  wire etec_mode_t    mode,
   input  wire logic [W-1:0]  exp_cycles,
   input  wire logic [W-1:0]  period_cycles,
   input  wire logic [W-1:0]  read_cycles,
   input  wire logic          syncb_mask_sel,
   input  wire logic          power_on,
   input  wire logic          cooled_variant,
   input  wire logic          cool_en,
   // Outputs
   output logic               sync_a,
   output logic               sync_b,
   output etec_lamps_t        lamps
);
   // --------------------------------------------------------------
   // Trigger synchroniser
   // --------------------------------------------------------------
   logic s1_r, s2_r, s3_r, trig_act;
   // Inverted so that an asserted pin reads as one
   assign trig_act = ~trig_n;
   // Reset value zero equals a released pin, so no false edge at start
   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= trig_act;
         s2_r <= s1_r;
         s3_r <= s2_r;                            // Edge history only
      end
   end
   // First stage may settle late, so only s2_r and s3_r feed logic
   // Pin high level means trigger not asserted
   logic pin_high, pin_high_d, rise, fall;
   assign pin_high   = ~s2_r;
   assign pin_high_d = ~s3_r;
   assign rise = pin_high & ~pin_high_d;
   assign fall = ~pin_high & pin_high_d;

   // --------------------------------------------------------------
   // Exposure, period and readout timers
   // --------------------------------------------------------------
   etec_exp_state_t st_r, st_nxt;
   logic [W-1:0] ecnt_r, ecnt_nxt, pcnt_r, pcnt_nxt, rcnt_r, rcnt_nxt;
   logic         rd_r, rd_nxt, exp_end;
   always_comb begin
      st_nxt   = st_r;
      ecnt_nxt = ecnt_r;
      pcnt_nxt = pcnt_r;
      rcnt_nxt = rcnt_r;
      rd_nxt   = rd_r;
      exp_end  = 1'b0;
      // Continuous mode: free running period timer
      if (mode == ETEC_MODE_CONT)
         pcnt_nxt = (pcnt_r >= period_cycles - W'(1)) ? '0 : pcnt_r + W'(1);
      else
         pcnt_nxt = '0;
      unique case (st_r)
         ETEC_EXP_IDLE: begin
            ecnt_nxt = '0;
            // Start is not gated by readout, so frames overlap
            unique case (mode)
               ETEC_MODE_CONT:      if (pcnt_r == '0) st_nxt = ETEC_EXP_RUN;
               ETEC_MODE_EDGE_RISE: if (rise) st_nxt = ETEC_EXP_RUN;
               ETEC_MODE_EDGE_FALL: if (fall) st_nxt = ETEC_EXP_RUN;
               ETEC_MODE_LVL_HIGH:  if (pin_high) st_nxt = ETEC_EXP_RUN;
               ETEC_MODE_LVL_LOW:   if (!pin_high) st_nxt = ETEC_EXP_RUN;
               default:             st_nxt = ETEC_EXP_IDLE;
            endcase
         end
         ETEC_EXP_RUN: begin
            // An exp_cycles of zero would wrap the end compare; one is the minimum
            ecnt_nxt = ecnt_r + W'(1);
            unique case (mode)
               ETEC_MODE_LVL_HIGH: exp_end = ~pin_high;
               ETEC_MODE_LVL_LOW:  exp_end = pin_high;
               default:            exp_end = (ecnt_r >= exp_cycles - W'(1));
            endcase
            if (exp_end) st_nxt = ETEC_EXP_IDLE;
         end
         default: st_nxt = ETEC_EXP_IDLE;
      endcase
      // Readout length is a setting because the sensor is not modelled
      // Readout follows each exposure; a new end restarts it
      if (exp_end) begin
         rd_nxt   = 1'b1;
         rcnt_nxt = '0;
      end else if (rd_r) begin
         rcnt_nxt = rcnt_r + W'(1);
         if (rcnt_r >= read_cycles - W'(1)) rd_nxt = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_r   <= ETEC_EXP_IDLE;
         ecnt_r <= '0;
         pcnt_r <= '0;
         rcnt_r <= '0;
         rd_r   <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         ecnt_r <= ecnt_nxt;
         pcnt_r <= pcnt_nxt;
         rcnt_r <= rcnt_nxt;
         rd_r   <= rd_nxt;
      end
   end

   // --------------------------------------------------------------
   // Output registers
   // --------------------------------------------------------------
   logic        exposing, mask, sync_b_nxt;
   etec_lamps_t lamps_nxt;
   assign exposing = (st_nxt == ETEC_EXP_RUN);
   // Mask: trigger would be ignored (busy exposing or not triggered)
   assign mask = exposing | (mode == ETEC_MODE_CONT);
   // Next values of the lamp and second sync registers
   always_comb begin
      lamps_nxt.power  = power_on;
      lamps_nxt.expose = exposing;
      lamps_nxt.cool   = cooled_variant & cool_en;
      sync_b_nxt       = syncb_mask_sel ? mask : exposing;
   end
   // Every output leaves a flop, so the pins never glitch
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         lamps  <= '0;
      end else begin
         sync_a <= rd_nxt;
         sync_b <= sync_b_nxt;
         lamps  <= lamps_nxt;
      end
   end

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   a_lamp_expose: assert property (@(posedge mclk) disable iff (reset)
      lamps.expose == (st_r == ETEC_EXP_RUN))
      else $error("exposure lamp disagrees with state");
   a_power_lamp: assert property (@(posedge mclk) disable iff (reset)
      lamps.power == $past(power_on))
      else $error("power lamp wrong");
   a_cool_lamp: assert property (@(posedge mclk) disable iff (reset)
      lamps.cool |-> $past(cooled_variant) && $past(cool_en))
      else $error("cool lamp lit without cooling");
   a_edge_start: assert property (@(posedge mclk) disable iff (reset)
      (mode == ETEC_MODE_EDGE_RISE && st_r == ETEC_EXP_IDLE && rise) |=> lamps.expose)
      else $error("rising edge did not start exposure");
   a_level_high: assert property (@(posedge mclk) disable iff (reset)
      (mode == ETEC_MODE_LVL_HIGH && $stable(mode)) |=> (lamps.expose == $past(pin_high)))
      else $error("level high exposure mismatch");
   a_level_low: assert property (@(posedge mclk) disable iff (reset)
      (mode == ETEC_MODE_LVL_LOW && $stable(mode)) |=> (lamps.expose == !$past(pin_high)))
      else $error("level low exposure mismatch");
   a_readout_sync: assert property (@(posedge mclk) disable iff (reset)
      (st_r == ETEC_EXP_RUN && exp_end) |=> sync_a)
      else $error("readout sync missing after exposure");
   a_syncb_mode: assert property (@(posedge mclk) disable iff (reset)
      !$past(syncb_mask_sel) |-> sync_b == lamps.expose)
      else $error("second sync not showing exposure");
   a_overlap_ok: assert property (@(posedge mclk) disable iff (reset)
      (mode == ETEC_MODE_EDGE_FALL && st_r == ETEC_EXP_IDLE && fall && rd_r) |=> lamps.expose)
      else $error("edge refused during readout");
   a_cont_mask: assert property (@(posedge mclk) disable iff (reset)
      ($past(syncb_mask_sel) && $past(mode) == ETEC_MODE_CONT) |-> sync_b)
      else $error("second sync not masking in continuous mode");
   a_sync_depth: assert property (@(posedge mclk) disable iff (reset)
      (!$past(reset) && !$past(reset, 2)) |-> (s2_r == !$past(trig_n, 2)))
      else $error("trigger synchroniser depth wrong");
   a_cont_ignore: assert property (@(posedge mclk) disable iff (reset)
      (mode == ETEC_MODE_CONT && st_r == ETEC_EXP_IDLE && pcnt_r != '0) |=> !lamps.expose)
      else $error("continuous exposure started off the period timer");
   a_exp_hold: assert property (@(posedge mclk) disable iff (reset)
      (st_r == ETEC_EXP_RUN && (mode == ETEC_MODE_EDGE_RISE || mode == ETEC_MODE_EDGE_FALL)
         && ecnt_r < exp_cycles - W'(1)) |=> lamps.expose)
      else $error("timed exposure ended early");
   a_exp_stop: assert property (@(posedge mclk) disable iff (reset)
      (st_r == ETEC_EXP_RUN && (mode == ETEC_MODE_EDGE_RISE || mode == ETEC_MODE_EDGE_FALL)
         && ecnt_r == exp_cycles - W'(1)) |=> (!lamps.expose && sync_a))
      else $error("timed exposure did not end on count");
   a_readout_hold: assert property (@(posedge mclk) disable iff (reset)
      (rd_r && !exp_end && rcnt_r < read_cycles - W'(1)) |=> sync_a)
      else $error("readout sync dropped early");
   a_bad_mode_idle: assert property (@(posedge mclk) disable iff (reset)
      (mode > ETEC_MODE_LVL_LOW && st_r == ETEC_EXP_IDLE) |=> !lamps.expose)
      else $error("exposure started in an unused mode");
endmodule
`default_nettype wire

// ### logic/etec_consts.svh
// Constant macros for the trigger and exposure controller
`ifndef ETEC_CONSTS_SVH
`define ETEC_CONSTS_SVH
`define ETEC_EXP_W          24
`define ETEC_EXP_RST        24'h0003E8
`define ETEC_PERIOD_RST     24'h002710
`define ETEC_READ_RST       24'h000800
`define ETEC_SYNC_STAGES    2
`endif

// ### logic/etec_pkg.sv
// Types for the trigger and exposure controller
`default_nettype none
package etec_pkg;
   // Trigger mode select
   typedef enum logic [2:0] {
      ETEC_MODE_CONT      = 3'h0,
      ETEC_MODE_EDGE_RISE = 3'h1,
      ETEC_MODE_EDGE_FALL = 3'h2,
      ETEC_MODE_LVL_HIGH  = 3'h3,
      ETEC_MODE_LVL_LOW   = 3'h4
   } etec_mode_t;
   // Exposure state, Gray along idle-expose
   typedef enum logic [1:0] {
      ETEC_EXP_IDLE = 2'b00,
      ETEC_EXP_RUN  = 2'b01
   } etec_exp_state_t;
   // Lamp group
   typedef struct packed {
      logic power;
      logic expose;
      logic cool;
   } etec_lamps_t;
endpackage
`default_nettype wire

// ### tb/etec_trig_src.sv
// Trigger source model: logic-level pulses on the trigger pin
`timescale 1ns/10ps
`default_nettype none
module etec_trig_src (
   // Clock and request
   input  wire logic       mclk,
   input  wire logic       go,
   input  wire logic       idle_lvl,
   input  wire logic [7:0] width,
   // Trigger pin
   output logic            trig_n
);
   logic [7:0] left_r = 8'h00;
   // Pulse leaves idle level for width cycles, one pulse at a time
   always @(posedge mclk) begin
      if (go && left_r == 8'h00)
         left_r <= width;
      else if (left_r != 8'h00)
         left_r <= left_r - 8'h01;
   end
   assign trig_n = (left_r != 8'h00) ? ~idle_lvl : idle_lvl;
endmodule
`default_nettype wire

// ### tb/etec_top_tb.sv
// Self-checking bench for the trigger and exposure controller
`timescale 1ns/10ps
`default_nettype none
module etec_top_tb;
   import etec_pkg::*;
   logic mclk = 1'b0, reset = 1'b1, go = 1'b0, idle_lvl = 1'b0, trig_n, sync_a, sync_b;
   logic mask_sel = 1'b0, power_on = 1'b0, cooled = 1'b0, cool_en = 1'b0, was_a = 1'b0;
   logic [7:0] width = 8'h10;
   logic [23:0] exp_cyc = 24'h000004, period = 24'h000020, rd = 24'h000028;
   etec_mode_t mode = etec_mode_t'(3'h7);
   etec_lamps_t lamps;
   int bad_count = 0, n_compared = 0, len = 0, since = 0, n_rd = 0;
   logic [23:0] exp_q[$];
   always #2 mclk = ~mclk;
   etec_trig_src src_u (.mclk(mclk), .go(go), .idle_lvl(idle_lvl), .width(width), .trig_n(trig_n));
   etec_top dut_u (.mclk(mclk), .reset(reset), .trig_n(trig_n), .mode(mode),
      .exp_cycles(exp_cyc), .period_cycles(period), .read_cycles(rd),
      .syncb_mask_sel(mask_sel), .power_on(power_on), .cooled_variant(cooled),
      .cool_en(cool_en), .sync_a(sync_a), .sync_b(sync_b), .lamps(lamps));
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Bounded wait until every noted exposure has been seen
   task automatic drain();
      for (int t = 0; t < 500 && exp_q.size() != 0; t++) tick(1);
      if (exp_q.size() != 0) begin
         bad_count++;
         $display("[ERR] %0t exposure timeout", $time);
         test_done();
      end
   endtask
   // Watcher: exposure width, readout length, sync_b copy
   always @(negedge mclk) begin
      if (lamps.expose === 1'b1) len++;
      else if (len != 0) begin
         if (exp_q.size() == 0) check(24'(len), 24'h0);
         else check(24'(len), exp_q.pop_front());
         len = 0;
         since = 0;
      end
      if (sync_a === 1'b1) since++;
      else if (was_a) begin
         check(24'(since), rd);
         n_rd++;
      end
      was_a = (sync_a === 1'b1);
      if (!mask_sel && mode != ETEC_MODE_CONT) check(sync_b, lamps.expose);
   end
   initial begin
      void'($urandom(10086));
      tick(10);
      reset = 1'b0;
      // Lamps follow power and cooling settings; invalid mode stays idle
      for (int i = 0; i < 8; i++) begin
         {power_on, cooled, cool_en} = i[2:0];
         tick(3);
         check(lamps.power, power_on);
         check(lamps.cool, cooled & cool_en);
      end
      // Each external mode; idle level changed while the mode is parked
      for (int m = 1; m < 5; m++) begin
         mode = etec_mode_t'(3'h7);
         idle_lvl = (m == 2 || m == 4);
         tick(6);
         mode = etec_mode_t'(m);
         tick(2);
         for (int k = 0; k < 3; k++) begin
            exp_cyc = 24'($urandom_range(9, 2));
            width = 8'($urandom_range(15, 4));
            exp_q.push_back(m < 3 ? exp_cyc : 24'(width));
            go = 1'b1;
            tick(1);
            go = 1'b0;
            tick(width + 8); // Next trigger lands inside readout
         end
         drain();
      end
      // Continuous mode ignores the pin; sync_b shows the mask
      exp_cyc = 24'h000004;
      mask_sel = 1'b1;
      mode = ETEC_MODE_CONT;
      exp_q.push_back(exp_cyc);
      exp_q.push_back(exp_cyc);
      go = 1'b1;
      tick(4);
      go = 1'b0;
      // Looked at between exposures, so only the mask can hold it high
      tick(6);
      check(sync_b, 1'b1);
      check(lamps.expose, 1'b0);
      drain();
      mode = etec_mode_t'(3'h7);
      tick(60);
      check(sync_a, 1'b0);
      // Every exposure after the first came inside readout, so it ended only once
      check(24'(n_rd), 24'h1);
      test_done();
   end
endmodule
`default_nettype wire
